// ==== shared/lfr_pkg.sv ====
package lfr_pkg;

	// Incoming byte word: control byte target in the top two bits
	localparam int          FIFO_WIDTH      = 10;
	localparam int          FIFO_DEPTH      = 16;
	localparam int          WORD_TGT_HI     = 9;
	localparam int          WORD_TGT_LO     = 8;
	localparam logic [1:0]  TARGET_RAM      = 2'h1;

	// Command byte patterns
	localparam logic [2:0]  FRAME_CMD_TAG   = 3'h1;
	localparam logic [1:0]  PTR_CMD_TAG     = 2'h2;
	localparam logic [5:0]  MUX_CMD_TAG     = 6'h00;
	localparam logic [5:0]  BIAS_CMD_TAG    = 6'h01;

	// Reset values and last valid prescaler code
	localparam logic [4:0]  RATE_CODE_RST   = 5'h0e;
	localparam logic [4:0]  RATE_CODE_LAST  = 5'h16;
	localparam logic [5:0]  PTR_RST         = 6'h00;
	localparam logic [3:0]  MODE_RST        = 4'h0;
	localparam logic [2:0]  OSC_RST         = 3'h0;
	localparam logic [1:0]  MUX_RST         = 2'h0;
	localparam logic [1:0]  BIAS_RST        = 2'h0;

	// Multiplex codes, last valid RAM address per code and RAM depth
	localparam logic [1:0]  MUX_SIX         = 2'h2;
	localparam logic [1:0]  MUX_FOUR        = 2'h3;
	localparam logic [5:0]  PTR_LAST_EIGHT  = 6'h27;
	localparam logic [5:0]  PTR_LAST_SIX    = 6'h29;
	localparam logic [5:0]  PTR_LAST_FOUR   = 6'h2b;
	localparam int          RAM_DEPTH       = 44;

	// Bit positions in the mode and oscillator settings
	localparam int          MODE_SWAP_BIT   = 3;
	localparam int          MODE_FLIP_BIT   = 2;
	localparam int          MODE_SLEEP_BIT  = 1;
	localparam int          MODE_ENABLE_BIT = 0;
	localparam int          OSC_RATE_BIT    = 2;
	localparam int          OSC_DRIVE_BIT   = 1;
	localparam int          OSC_EXT_BIT     = 0;

	// Timing
	localparam longint      CORE_CLK_HZ     = 100000000;
	localparam longint      OSC_HZ          = 230000;
	localparam int          OSC_TICK_CYCLES = int'(CORE_CLK_HZ / OSC_HZ);
	localparam logic [6:0]  FRAME_DIV       = 7'd48;
	localparam logic [6:0]  BYPASS_DIV      = 7'd1;

	typedef enum logic [0:0] {
		PTR_HALTED = 1'b0,
		PTR_ARMED  = 1'b1
	} lfr_ptr_state_t;

	// Divide factor q for each prescaler code
	function automatic logic [6:0] lfr_q_of(input logic [4:0] code);
		logic [6:0] q;
		q = 7'd24;
		case (code)
			5'h00: q = 7'd80;
			5'h01: q = 7'd68;
			5'h02: q = 7'd60;
			5'h03: q = 7'd53;
			5'h04: q = 7'd48;
			5'h05: q = 7'd44;
			5'h06: q = 7'd40;
			5'h07: q = 7'd37;
			5'h08: q = 7'd34;
			5'h09: q = 7'd32;
			5'h0a: q = 7'd30;
			5'h0b: q = 7'd28;
			5'h0c: q = 7'd27;
			5'h0d: q = 7'd25;
			5'h0e: q = 7'd24;
			5'h0f: q = 7'd23;
			5'h10: q = 7'd22;
			5'h11: q = 7'd21;
			5'h12: q = 7'd20;
			5'h13: q = 7'd19;
			5'h14: q = 7'd18;
			5'h15: q = 7'd17;
			5'h16: q = 7'd16;
			default: q = 7'd24;
		endcase
		return q;
	endfunction : lfr_q_of

endpackage : lfr_pkg

// ==== logic/lfr_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module lfr_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_reg [DEPTH];
	logic [AW-1:0]    wr_idx_reg;
	logic [AW-1:0]    rd_idx_reg;
	logic [AW:0]      fill_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (fill_reg != (AW+1)'(DEPTH));
	assign out_valid = (fill_reg != '0);
	assign out_data  = store_reg[rd_idx_reg];
	assign push      = clk_en && in_valid && in_ready;
	assign pop       = clk_en && out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (push)
			store_reg[wr_idx_reg] <= in_data;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_idx_reg <= '0;
			rd_idx_reg <= '0;
			fill_reg   <= '0;
		end else begin
			if (push)
				wr_idx_reg <= (wr_idx_reg == AW'(DEPTH - 1)) ? '0 : wr_idx_reg + AW'(1);
			if (pop)
				rd_idx_reg <= (rd_idx_reg == AW'(DEPTH - 1)) ? '0 : rd_idx_reg + AW'(1);
			if (push && !pop)
				fill_reg <= fill_reg + (AW+1)'(1);
			else if (pop && !push)
				fill_reg <= fill_reg - (AW+1)'(1);
		end
	end
endmodule : lfr_fifo
`default_nettype wire

// ==== logic/lfr_divider.sv ====
`timescale 1ns/1ns
`default_nettype none
module lfr_divider (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic       run,
	input  wire logic       tick,
	input  wire logic [6:0] divisor,
	output logic            pulse,
	output logic            level_reg
);
	logic [6:0] count_reg;
	logic       wrap;

	assign wrap  = (count_reg >= divisor - 7'd1);
	assign pulse = run && tick && wrap;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			count_reg <= '0;
		else if (clk_en && !run)
			count_reg <= '0;
		else if (clk_en && tick)
			count_reg <= wrap ? 7'd0 : count_reg + 7'd1;
	end

	// High for the first half of each period; duty varies with odd divisors
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			level_reg <= 1'b0;
		else if (clk_en)
			level_reg <= run && (count_reg < (divisor >> 1));
	end
endmodule : lfr_divider
`default_nettype wire

// ==== logic/lfr_loader.sv ====
`timescale 1ns/1ns
`default_nettype none
module lfr_loader
	import lfr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	// Byte stream from the serial framer
	input  wire logic       byte_valid,
	output logic            byte_ready,
	input  wire logic [7:0] byte_data,
	input  wire logic [1:0] control_byte_target,
	// Commands decoded elsewhere
	input  wire logic       mode_load,
	input  wire logic [3:0] mode_value,
	input  wire logic       osc_load,
	input  wire logic [2:0] osc_value,
	// Display scan read port, has priority over loading
	input  wire logic       scan_read,
	input  wire logic [5:0] scan_index,
	output logic      [7:0] scan_data_reg,
	// Clock pin
	input  wire logic       clock_pin_in,
	output logic            clock_pin_out,
	output logic            clock_pin_oe,
	// Configuration and timing out
	output logic            lcd_drive_enable,
	output logic            backplane_swap,
	output logic            polarity_flip,
	output logic            sleep_request,
	output logic      [1:0] backplane_count_select,
	output logic      [1:0] bias_level_select,
	output logic      [4:0] rate_divider_code,
	output logic      [5:0] ram_write_index,
	output logic            ram_write_armed,
	output logic            frame_pulse
);

	logic [4:0]           frame_rate_divider_code_reg;
	logic [5:0]           ram_write_pointer_reg;
	logic [5:0]           ram_write_pointer_next;
	logic [3:0]           display_mode_settings_reg;
	logic [2:0]           clock_source_settings_reg;
	logic [1:0]           backplane_count_select_reg;
	logic [1:0]           bias_level_select_reg;
	lfr_ptr_state_t       ptr_state_reg;
	lfr_ptr_state_t       ptr_state_next;
	logic [7:0]           ram_reg [RAM_DEPTH];

	logic                 q_valid;
	logic                 q_ready;
	logic [FIFO_WIDTH-1:0] q_word;
	logic [7:0]           q_byte;
	logic [1:0]           q_target;
	logic                 take;
	logic                 is_ram_byte;
	logic                 is_frame_cmd;
	logic                 is_ptr_cmd;
	logic                 is_mux_cmd;
	logic                 is_bias_cmd;
	logic [5:0]           ptr_last;
	logic                 ram_write;

	logic [8:0]           osc_count_reg;
	logic                 osc_tick;
	logic                 pin_sample_reg;
	logic                 pin_prev_reg;
	logic                 ext_edge;
	logic                 ext_src;
	logic                 base_tick;
	logic [6:0]           stage_div;
	logic                 mid_pulse;
	logic                 mid_level;
	logic                 div_run;

	// Input buffer; scan reads stall the drain so the buffer can fill
	lfr_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.in_valid  (byte_valid),
		.in_ready  (byte_ready),
		.in_data   ({control_byte_target, byte_data}),
		.out_valid (q_valid),
		.out_ready (q_ready),
		.out_data  (q_word)
	);

	assign q_ready  = !scan_read;
	assign take     = clk_en && q_valid && q_ready;
	assign q_byte   = q_word[7:0];
	assign q_target = q_word[WORD_TGT_HI:WORD_TGT_LO];

	// Command classification
	always_comb begin
		is_ram_byte  = (q_target == TARGET_RAM);
		is_frame_cmd = !is_ram_byte && (q_byte[7:5] == FRAME_CMD_TAG);
		is_ptr_cmd   = !is_ram_byte && (q_byte[7:6] == PTR_CMD_TAG);
		is_mux_cmd   = !is_ram_byte && (q_byte[7:2] == MUX_CMD_TAG);
		is_bias_cmd  = !is_ram_byte && (q_byte[7:2] == BIAS_CMD_TAG);
	end

	// Last valid address for the current multiplex mode
	always_comb begin
		case (backplane_count_select_reg)
			MUX_SIX:  ptr_last = PTR_LAST_SIX;
			MUX_FOUR: ptr_last = PTR_LAST_FOUR;
			default:  ptr_last = PTR_LAST_EIGHT;
		endcase
	end

	assign ram_write = take && is_ram_byte && (ptr_state_reg == PTR_ARMED)
		&& (ram_write_pointer_reg <= ptr_last);

	// Prescaler code
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			frame_rate_divider_code_reg <= RATE_CODE_RST;
		else if (take && is_frame_cmd && q_byte[4:0] <= RATE_CODE_LAST)
			frame_rate_divider_code_reg <= q_byte[4:0];
	end

	// Multiplex and bias selection
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			backplane_count_select_reg <= MUX_RST;
			bias_level_select_reg      <= BIAS_RST;
		end else if (take) begin
			if (is_mux_cmd)
				backplane_count_select_reg <= q_byte[1:0];
			if (is_bias_cmd)
				bias_level_select_reg <= q_byte[1:0];
		end
	end

	// Mode and oscillator settings
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			display_mode_settings_reg <= MODE_RST;
			clock_source_settings_reg <= OSC_RST;
		end else if (clk_en) begin
			if (mode_load)
				display_mode_settings_reg <= mode_value;
			if (osc_load)
				clock_source_settings_reg <= osc_value;
		end
	end

	// Write pointer next state
	always_comb begin
		ram_write_pointer_next = ram_write_pointer_reg;
		ptr_state_next         = ptr_state_reg;
		case (ptr_state_reg)
			PTR_ARMED: begin
				if (ram_write) begin
					if (ram_write_pointer_reg == ptr_last)
						ptr_state_next = PTR_HALTED;
					else
						ram_write_pointer_next = ram_write_pointer_reg + 6'h01;
				end
			end
			PTR_HALTED: begin
				ptr_state_next = PTR_HALTED;
			end
			default: begin
				ptr_state_next = PTR_HALTED;
			end
		endcase
		if (take && is_ptr_cmd) begin
			if (q_byte[5:0] <= ptr_last) begin
				ram_write_pointer_next = q_byte[5:0];
				ptr_state_next         = PTR_ARMED;
			end else begin
				ptr_state_next = PTR_HALTED;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ram_write_pointer_reg <= PTR_RST;
			ptr_state_reg         <= PTR_ARMED;
		end else if (clk_en) begin
			ram_write_pointer_reg <= ram_write_pointer_next;
			ptr_state_reg         <= ptr_state_next;
		end
	end

	// Display RAM has no reset so contents survive it
	always_ff @(posedge core_clk) begin
		if (ram_write)
			ram_reg[ram_write_pointer_reg] <= q_byte;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			scan_data_reg <= 8'h00;
		else if (clk_en && scan_read)
			scan_data_reg <= (int'(scan_index) < RAM_DEPTH) ? ram_reg[scan_index] : 8'h00;
	end

	// Internal oscillator stand-in: a tick at the nominal rate
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			osc_count_reg <= '0;
		else if (clk_en)
			osc_count_reg <= osc_tick ? 9'd0 : osc_count_reg + 9'd1;
	end

	assign osc_tick = (osc_count_reg == 9'(OSC_TICK_CYCLES - 1));

	// External clock pin is taken as synchronous; rising edges count
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_sample_reg <= 1'b0;
			pin_prev_reg   <= 1'b0;
		end else if (clk_en) begin
			pin_sample_reg <= clock_pin_in;
			pin_prev_reg   <= pin_sample_reg;
		end
	end

	assign ext_edge  = pin_sample_reg && !pin_prev_reg;
	assign ext_src   = clock_source_settings_reg[OSC_EXT_BIT];
	assign base_tick = ext_src ? ext_edge : osc_tick;
	assign div_run   = !display_mode_settings_reg[MODE_SLEEP_BIT];

	// Slow external rate skips the q stage
	always_comb begin
		if (ext_src && !clock_source_settings_reg[OSC_RATE_BIT])
			stage_div = BYPASS_DIV;
		else
			stage_div = lfr_q_of(frame_rate_divider_code_reg);
	end

	// Intermediate clock: base clock divided by q, or by 1 when the q stage is skipped
	lfr_divider u_mid_div (
		.core_clk  (core_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.run       (div_run),
		.tick      (base_tick),
		.divisor   (stage_div),
		.pulse     (mid_pulse),
		.level_reg (mid_level)
	);

	// Frame rate: intermediate clock divided by 48
	lfr_divider u_frame_div (
		.core_clk  (core_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.run       (div_run),
		.tick      (mid_pulse),
		.divisor   (FRAME_DIV),
		.pulse     (frame_pulse),
		.level_reg ()
	);

	// Pin drives only with internal source; held high while asleep
	assign clock_pin_oe  = clock_source_settings_reg[OSC_DRIVE_BIT] && !ext_src;
	assign clock_pin_out = clock_pin_oe && (!div_run || mid_level);

	// Outputs
	assign lcd_drive_enable       = display_mode_settings_reg[MODE_ENABLE_BIT] && div_run;
	assign backplane_swap         = display_mode_settings_reg[MODE_SWAP_BIT];
	assign polarity_flip          = display_mode_settings_reg[MODE_FLIP_BIT];
	assign sleep_request          = display_mode_settings_reg[MODE_SLEEP_BIT];
	assign backplane_count_select = backplane_count_select_reg;
	assign bias_level_select      = bias_level_select_reg;
	assign rate_divider_code      = frame_rate_divider_code_reg;
	assign ram_write_index        = ram_write_pointer_reg;
	assign ram_write_armed        = (ptr_state_reg == PTR_ARMED);

endmodule : lfr_loader
`default_nettype wire

// ==== dv/lfr_loader_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module lfr_loader_asserts
	import lfr_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic       mode_load,
	input wire logic [3:0] mode_value,
	input wire logic       osc_load,
	input wire logic [2:0] osc_value,
	input wire logic       scan_read,
	input wire logic [5:0] scan_index,
	input wire logic [7:0] scan_data_reg,
	input wire logic       clock_pin_oe,
	input wire logic       lcd_drive_enable,
	input wire logic       backplane_swap,
	input wire logic       polarity_flip,
	input wire logic       sleep_request,
	input wire logic [1:0] backplane_count_select,
	input wire logic [4:0] rate_divider_code,
	input wire logic [5:0] ram_write_index,
	input wire logic       ram_write_armed,
	input wire logic       frame_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [5:0] last_idx;
	assign last_idx = (backplane_count_select == MUX_FOUR) ? PTR_LAST_FOUR :
		(backplane_count_select == MUX_SIX) ? PTR_LAST_SIX : PTR_LAST_EIGHT;
	a_ptr_range: assert property (ram_write_armed && $changed(ram_write_index) |->
		ram_write_index <= last_idx)
		else $error("armed pointer beyond last address");
	a_code_range: assert property (rate_divider_code <= RATE_CODE_LAST)
		else $error("unused rate code stored");
	a_drive_gate: assert property (lcd_drive_enable |-> !sleep_request)
		else $error("drive enabled while sleeping");
	a_mode_take: assert property (clk_en && mode_load |=>
		{backplane_swap, polarity_flip, sleep_request, 1'b0} == ($past(mode_value) & 4'he))
		else $error("mode bits not loaded");
	a_pin_drive: assert property (clk_en && osc_load |=>
		clock_pin_oe == (($past(osc_value) & 3'h3) == 3'h2))
		else $error("clock pin drive wrong");
	a_scan_void: assert property (clk_en && scan_read && scan_index > 6'h2b |=>
		scan_data_reg == 8'h00)
		else $error("scan beyond ram not zero");
	a_pulse_one: assert property ($rose(frame_pulse) |=> !frame_pulse)
		else $error("frame pulse too long");
	a_rst_vals: assert property ($fell(rst) |-> rate_divider_code == RATE_CODE_RST
		&& ram_write_index == PTR_RST && !clock_pin_oe && !lcd_drive_enable
		&& backplane_count_select == MUX_RST)
		else $error("reset values wrong");
endmodule : lfr_loader_asserts
bind lfr_loader lfr_loader_asserts chk_i (.core_clk, .rst, .clk_en, .mode_load, .mode_value,
	.osc_load, .osc_value, .scan_read, .scan_index, .scan_data_reg, .clock_pin_oe,
	.lcd_drive_enable, .backplane_swap, .polarity_flip, .sleep_request,
	.backplane_count_select, .rate_divider_code, .ram_write_index, .ram_write_armed,
	.frame_pulse);
`default_nettype wire

// ==== dv/lfr_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module lfr_host (
	input  wire logic       core_clk,
	input  wire logic       byte_ready,
	input  wire logic       clock_pin_out,
	input  wire logic       clock_pin_oe,
	output logic            byte_valid,
	output logic      [7:0] byte_data,
	output logic      [1:0] control_byte_target,
	output logic            clock_pin_in
);
	logic ext_on;
	logic ext_clk;
	// Device drive wins, else external clock or pin tied low
	assign clock_pin_in = clock_pin_oe ? clock_pin_out : (ext_on & ext_clk);
	initial begin
		byte_valid = 1'b0; // idle until first command
		byte_data = 8'h00;
		control_byte_target = 2'h0;
		ext_on = 1'b0;
		ext_clk = 1'b0;
		#3;
		forever #50 ext_clk = ~ext_clk;
	end
	task automatic send(input logic [7:0] b, input logic [1:0] t, output bit ok);
		byte_data <= b;
		control_byte_target <= t;
		byte_valid <= 1'b1;
		ok = 1'b0;
		for (int i = 0; i < 64 && !ok; i++) begin
			@(posedge core_clk);
			ok = byte_ready;
		end
		byte_valid <= 1'b0;
		byte_data <= ~b;
		@(posedge core_clk);
	endtask : send
endmodule : lfr_host
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb
	import lfr_pkg::*;
;
	typedef struct packed {logic [7:0] b; logic [1:0] t; logic [4:0] c; logic [5:0] i; logic a;} lfr_row_t;
	logic       core_clk, rst, clk_en, mode_load, osc_load, scan_read;
	logic [3:0] mode_value;
	logic [2:0] osc_value;
	logic [5:0] scan_index;
	wire logic  byte_valid, byte_ready, clock_pin_in, clock_pin_out, clock_pin_oe, frame_pulse;
	wire logic  lcd_drive_enable, backplane_swap, polarity_flip, sleep_request, ram_write_armed;
	wire logic [7:0] byte_data, scan_data_reg;
	wire logic [1:0] control_byte_target, backplane_count_select, bias_level_select;
	wire logic [4:0] rate_divider_code;
	wire logic [5:0] ram_write_index;
	int         err_count, n_tests, cnt;
	bit         ok;
	lfr_row_t   rows [20] = '{'{8'h20,2'h0,5'h00,6'h00,1'b1}, '{8'h36,2'h0,5'h16,6'h00,1'b1},
		'{8'h37,2'h0,5'h16,6'h00,1'b1}, '{8'h8a,2'h0,5'h16,6'h0a,1'b1}, '{8'ha8,2'h0,5'h16,6'h0a,1'b0},
		'{8'h55,2'h1,5'h16,6'h0a,1'b0}, '{8'h85,2'h0,5'h16,6'h05,1'b1}, '{8'h3c,2'h1,5'h16,6'h06,1'b1},
		'{8'hc3,2'h1,5'h16,6'h07,1'b1}, '{8'h11,2'h1,5'h16,6'h08,1'b1}, '{8'h87,2'h0,5'h16,6'h07,1'b1},
		'{8'h59,2'h2,5'h16,6'h07,1'b1}, '{8'h07,2'h0,5'h16,6'h07,1'b1}, '{8'h02,2'h0,5'h16,6'h07,1'b1},
		'{8'haa,2'h0,5'h16,6'h07,1'b0}, '{8'ha9,2'h0,5'h16,6'h29,1'b1}, '{8'h03,2'h0,5'h16,6'h29,1'b1},
		'{8'hab,2'h0,5'h16,6'h2b,1'b1}, '{8'h77,2'h1,5'h16,6'h2b,1'b0}, '{8'h88,2'h1,5'h16,6'h2b,1'b0}};
	lfr_host host (.core_clk, .byte_ready, .clock_pin_out, .clock_pin_oe, .byte_valid, .byte_data,
		.control_byte_target, .clock_pin_in);
	lfr_loader dut (.core_clk, .rst, .clk_en, .byte_valid, .byte_ready, .byte_data,
		.control_byte_target, .mode_load, .mode_value, .osc_load, .osc_value, .scan_read,
		.scan_index, .scan_data_reg, .clock_pin_in, .clock_pin_out, .clock_pin_oe,
		.lcd_drive_enable, .backplane_swap, .polarity_flip, .sleep_request,
		.backplane_count_select, .bias_level_select, .rate_divider_code, .ram_write_index,
		.ram_write_armed, .frame_pulse);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wrap_up;
		$display("mismatches %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic scan(input logic [5:0] i, input logic [7:0] exp);
		scan_read <= 1'b1;
		scan_index <= i;
		@(posedge core_clk);
		#1 chk("scan_data_reg", scan_data_reg, exp);
		@(posedge core_clk);
		scan_read <= 1'b0;
		@(posedge core_clk);
	endtask : scan
	task automatic ld(input bit osc, input logic [3:0] v);
		mode_value <= v;
		osc_value <= v[2:0];
		mode_load <= !osc;
		osc_load <= osc;
		@(posedge core_clk);
		mode_load <= 1'b0;
		osc_load <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask : ld
	task automatic gap(input bit frm, input int exp);
		int n, k;
		logic pv, cur;
		n = 0;
		k = 0;
		pv = 1'b1;
		for (int c = 0; c < 40000 && k < 2; c++) begin
			@(posedge core_clk);
			#1 cur = frm ? frame_pulse : clock_pin_out;
			if (cur === 1'b1 && pv === 1'b0) begin
				if (k == 1)
					chk("period", n[15:0], exp[15:0]);
				k++;
				n = 0;
			end
			n++;
			pv = cur;
		end
		if (k < 2) begin
			err_count++;
			wrap_up();
		end
	endtask : gap
	task automatic rst_chk;
		chk("enable", lcd_drive_enable, 1'b0);
		chk("mux_bias", {backplane_count_select, bias_level_select}, 4'h0);
		chk("index", {ram_write_armed, ram_write_index}, 7'h40);
		chk("pin_oe", clock_pin_oe, 1'b0);
		chk("code_mode", {rate_divider_code, backplane_swap, polarity_flip, sleep_request}, 8'h70);
	endtask : rst_chk
	initial begin
		{rst, clk_en, mode_load, osc_load, scan_read} = 5'h18;
		{mode_value, osc_value, scan_index} = '0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1 rst_chk();
		foreach (rows[r]) begin
			host.send(rows[r].b, rows[r].t, ok);
			if (!ok) begin
				err_count++;
				wrap_up();
			end
			repeat (4) @(posedge core_clk);
			#1 chk("code", rate_divider_code, rows[r].c);
			chk("index", {ram_write_armed, ram_write_index}, {rows[r].a, rows[r].i});
		end
		chk("mux_bias", {backplane_count_select, bias_level_select}, 4'hf);
		scan(6'h05, 8'h3c);
		scan(6'h06, 8'hc3);
		scan(6'h07, 8'h11);
		scan(6'h2b, 8'h77);
		scan(6'h32, 8'h00);
		ld(0, 4'h1); // RAM filled before enabling
		chk("enable", lcd_drive_enable, 1'b1);
		ld(0, 4'h3);
		chk("sleep", {lcd_drive_enable, sleep_request}, 2'h1);
		ld(0, 4'hc);
		chk("swap_flip", {backplane_swap, polarity_flip, sleep_request}, 3'h6);
		clk_en <= 1'b0;
		ld(0, 4'h1);
		chk("frozen", lcd_drive_enable, 1'b0);
		clk_en <= 1'b1;
		scan_read <= 1'b1;
		cnt = 0;
		for (int i = 0; i < 17; i++) begin
			host.send(8'h80 | i[7:0], 2'h0, ok);
			cnt += ok;
		end
		scan_read <= 1'b0;
		repeat (40) @(posedge core_clk);
		#1 chk("fifo_fill", cnt[15:0], 16'd16);
		chk("index", ram_write_index, 6'h0f);
		ld(1, 4'h2);
		chk("pin_oe", clock_pin_oe, 1'b1);
		gap(0, OSC_TICK_CYCLES * 16);
		host.ext_on <= 1'b1;
		ld(1, 4'h1); // rate bit matches the 10-cycle clock
		chk("pin_oe", clock_pin_oe, 1'b0);
		gap(1, 480);
		ld(1, 4'h5);
		gap(1, 48 * 16 * 10);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1 rst_chk();
		scan(6'h05, 8'h3c);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
